// ===== design/clock_source_startup_control.sv
// clock source decode, start-up sequencing and clock domain gating
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Contract
// RQ1: decode source field into crystal, low-frequency crystal, RC, external or reserved
// RQ2: fuse bit one means unprogrammed, zero means programmed
// RQ3: after power-down/save wake, count selected-clock cycles before resuming execution
// RQ4: reset adds watchdog-oscillator delay of 4096 or 65536 cycles
// RQ5: shipped fuses: source 0010, start-up 10, divide-by-eight programmed
// RQ6: crystal band from upper three select bits
// RQ7: crystal bit0=0: codes 00,01 give 258 clocks; 10 gives 1K, 14 clocks only
// RQ8: bit0=0 code 11: 1K plus 4.1 ms; bit0=1 code 00: 1K plus 65 ms
// RQ9: bit0=1 codes 01,10,11: 16K clocks; reset adds none, 4.1 ms, 65 ms
// RQ10: gate unused clock domains according to sleep mode
// RQ11: core clock stop halts core; peripheral clock drives timers and serial units
// RQ12: serial start detection works asynchronously while peripheral clock halted
// RQ13: program memory clock runs with the core clock
// RQ14: async timer clock keeps running in sleep modes
// RQ15: converter clock runs while core and peripheral clocks halted
// RQ16: RC and external clock: 6 clocks from sleep, reset 14/4.1ms/65ms, 11 reserved; code gives 11 the 65 ms delay
// RQ17: hold execution until reset delay and clock start-up count both complete
// RQ18: reserved source codes fall back to the internal RC oscillator
module clock_source_startup_control import clk_startup_pkg::*; (
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // oscillator and watchdog oscillator cycle enables
  input  wire logic        osc_tick,
  input  wire logic        wdt_tick,
  input  wire logic        osc_running,
  // sleep request and wake events
  input  wire logic        sleep_req,
  input  wire logic        wake_evt,
  input  wire logic        serial_start_async,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // clock domain enables
  output logic             core_clock_en,
  output logic             peripheral_clock_en,
  output logic             program_memory_clock_en,
  output logic             async_timer_clock_en,
  output logic             converter_clock_en,
  output logic             serial_start_wake,
  // decoded configuration
  output logic [2:0]       source_class,
  output logic [2:0]       oscillator_band_select,
  output logic             divide_by_eight_en,
  output logic             run_enable
);

  typedef enum logic [2:0] {
    ST_RESET_WDT, ST_RESET_CLK, ST_RUN, ST_SLEEP, ST_WAKE_CLK
  } seq_state_t;

  seq_state_t  state_r, state_nxt;
  logic [6:0]  fuse_r;
  sleep_mode_t mode_r;
  logic        done_seen_r;

  // fuse fields
  wire logic [3:0] clock_source_select_field = fuse_r[3:0];
  wire logic [1:0] startup_delay_field       = fuse_r[5:4];
  wire logic       divide_by_eight_fuse      = fuse_r[6];
  wire logic       startup_group_select_bit  = clock_source_select_field[0];

  // source decode; reserved codes fall back to RC timing
  source_t src;
  assign src = clock_source_select_field[3]           ? SRC_XTAL :    // RQ1
               (clock_source_select_field[3:1] == 3'h3) ? SRC_LF_XTAL :
               (clock_source_select_field == CSS_RC_OSC)    ? SRC_RC :
               (clock_source_select_field == CSS_EXT_CLOCK) ? SRC_EXT : SRC_BAD;
  wire source_t eff_src = (src == SRC_BAD) ? SRC_RC : src;              // RQ18
  assign source_class           = src;
  assign oscillator_band_select = (src == SRC_XTAL) ? clock_source_select_field[3:1] : 3'h0; // RQ6
  assign divide_by_eight_en     = !divide_by_eight_fuse;                 // RQ2

  // start-up table: sleep wake count and reset watchdog selection
  logic [16:0] wake_cnt;
  logic [1:0]  rst_sel;   // 0 none, 1 short, 2 long
  always_comb begin
    wake_cnt = 17'(CK_6);
    rst_sel  = 2'd0;
    unique case (eff_src)
      SRC_XTAL: begin
        unique case ({startup_group_select_bit, startup_delay_field})
          3'b000: begin wake_cnt = 17'(CK_258); rst_sel = 2'd1; end   // RQ7
          3'b001: begin wake_cnt = 17'(CK_258); rst_sel = 2'd2; end   // RQ7
          3'b010: begin wake_cnt = 17'(CK_1K);  rst_sel = 2'd0; end   // RQ7
          3'b011: begin wake_cnt = 17'(CK_1K);  rst_sel = 2'd1; end   // RQ8
          3'b100: begin wake_cnt = 17'(CK_1K);  rst_sel = 2'd2; end   // RQ8
          3'b101: begin wake_cnt = 17'(CK_16K); rst_sel = 2'd0; end   // RQ9
          3'b110: begin wake_cnt = 17'(CK_16K); rst_sel = 2'd1; end   // RQ9
          default: begin wake_cnt = 17'(CK_16K); rst_sel = 2'd2; end  // RQ9
        endcase
      end
      SRC_LF_XTAL: begin
        wake_cnt = startup_group_select_bit ? 17'(CK_32K) : 17'(CK_1K);
        rst_sel  = (startup_delay_field == 2'd3) ? 2'd2 : startup_delay_field;
      end
      default: begin
        wake_cnt = 17'(CK_6);                                             // RQ16
        rst_sel  = (startup_delay_field == 2'd3) ? 2'd2 : startup_delay_field; // RQ16
      end
    endcase
  end

  // reset-time clock count is 14 plus any watchdog delay
  wire logic [16:0] wdt_cnt = (rst_sel == 2'd2) ? 17'(WDT_LONG_CYC) :
                              (rst_sel == 2'd1) ? 17'(WDT_SHORT_CYC) : 17'd0;

  // counters: watchdog oscillator and selected clock
  startup_count_if wdt_if ();
  startup_count_if osc_if ();
  startup_counter #(.WIDTH(17)) u_wdt_cnt (.clk(clk), .rst_n(rst_n), .cif(wdt_if.cnt));
  startup_counter #(.WIDTH(17)) u_osc_cnt (.clk(clk), .rst_n(rst_n), .cif(osc_if.cnt));

  wire logic enter_reset_wdt = (state_r == ST_RESET_WDT) && !done_seen_r;
  wire logic wake_go         = (state_r == ST_SLEEP) && (wake_evt || serial_start_async);
  wire logic clk_go          = (state_r == ST_RESET_WDT) && done_seen_r && wdt_if.done
                               && osc_running;                            // RQ17
  assign wdt_if.start = enter_reset_wdt && (wdt_cnt != 17'd0);            // RQ4
  assign wdt_if.count = wdt_cnt;
  assign wdt_if.tick  = wdt_tick;                                         // RQ4
  assign osc_if.start = clk_go || (wake_go && osc_running);
  assign osc_if.count = clk_go ? 17'(CK_14) : wake_cnt;                   // RQ3
  assign osc_if.tick  = osc_tick;                                         // RQ3

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET_WDT: if (clk_go) state_nxt = ST_RESET_CLK;
      ST_RESET_CLK: if (osc_if.done) state_nxt = ST_RUN;                  // RQ17
      ST_RUN:       if (sleep_req) state_nxt = ST_SLEEP;
      ST_SLEEP: begin
        if (wake_go && osc_running) begin
          state_nxt = ((mode_r == SLP_PWR_DOWN) || (mode_r == SLP_PWR_SAVE)) ?
                      ST_WAKE_CLK : ST_RUN;                               // RQ3
        end
      end
      ST_WAKE_CLK:  if (osc_if.done) state_nxt = ST_RUN;                  // RQ3
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_RESET_WDT;
      done_seen_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      done_seen_r <= (state_r == ST_RESET_WDT);
    end
  end

  // clock domain gating per sleep mode
  wire logic running = (state_r == ST_RUN);
  wire logic asleep  = (state_r == ST_SLEEP) || (state_r == ST_WAKE_CLK);
  assign run_enable              = running;                               // RQ17
  assign core_clock_en           = running;                               // RQ11
  assign program_memory_clock_en = core_clock_en;                         // RQ13
  assign peripheral_clock_en     = running || (asleep && mode_r == SLP_IDLE); // RQ10
  assign converter_clock_en      = running || (asleep && (mode_r == SLP_IDLE ||
                                   mode_r == SLP_ADC_NR));                // RQ15
  assign async_timer_clock_en    = (src != SRC_XTAL) || asleep || running; // RQ14
  assign serial_start_wake       = asleep && !peripheral_clock_en && serial_start_async; // RQ12

  // axi4-lite slave: write side
  logic aw_got_r, w_got_r, bvalid_r, bad_w_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bad_w_r ? AXI_SLVERR : AXI_OKAY;
  wire logic aw_hs   = s_axi_awvalid && s_axi_awready;
  wire logic w_hs    = s_axi_wvalid && s_axi_wready;
  wire logic aw_have = aw_got_r || aw_hs;
  wire logic w_have  = w_got_r || w_hs;
  wire logic [7:0]  wa   = aw_got_r ? awaddr_r : s_axi_awaddr;
  wire logic [31:0] wd   = w_got_r ? wdata_r : s_axi_wdata;
  wire logic [3:0]  ws   = w_got_r ? wstrb_r : s_axi_wstrb;
  wire logic        do_w = aw_have && w_have && !bvalid_r;
  wire logic        wr_ok = (wa == FUSE_OFF) || (wa == SLEEP_OFF);
  // register write strobes, low byte only; decoded fuse outputs change as soon as the fuse register is written
  wire logic fuse_we  = do_w && (wa == FUSE_OFF) && ws[0];
  wire logic sleep_we = do_w && (wa == SLEEP_OFF) && ws[0] && (wd[2:0] <= 3'd4);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      bvalid_r <= 1'b0;
      bad_w_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else begin
      if (aw_hs) awaddr_r <= s_axi_awaddr;
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_got_r <= do_w ? 1'b0 : aw_have;
      w_got_r  <= do_w ? 1'b0 : w_have;
      if (do_w) begin
        bvalid_r <= 1'b1;
        bad_w_r  <= !wr_ok;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_r <= FUSE_RESET;                                               // RQ5
      mode_r <= SLP_IDLE;
    end else begin
      if (fuse_we) fuse_r <= wd[6:0];
      if (sleep_we) mode_r <= sleep_mode_t'(wd[2:0]);
    end
  end

  // axi4-lite slave: read side
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  wire logic [31:0] status_word = {24'h0, 1'b0, src == SRC_BAD, 1'b0, osc_running,
                                   1'b0, state_r};
  wire logic [31:0] gate_word   = {27'h0, converter_clock_en, async_timer_clock_en,
                                   program_memory_clock_en, peripheral_clock_en,
                                   core_clock_en};
  wire logic        rd_ok = (s_axi_araddr == FUSE_OFF) || (s_axi_araddr == SLEEP_OFF) ||
                            (s_axi_araddr == STATUS_OFF) || (s_axi_araddr == GATE_OFF);
  wire logic [31:0] rd_word = (s_axi_araddr == FUSE_OFF)   ? {25'h0, fuse_r} :
                              (s_axi_araddr == SLEEP_OFF)  ? {29'h0, mode_r} :
                              (s_axi_araddr == STATUS_OFF) ? status_word :
                              (s_axi_araddr == GATE_OFF)   ? gate_word : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= AXI_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule : clock_source_startup_control
`default_nettype wire

// ===== design/clk_startup_pkg.sv
// constants, register map and types for the clock start-up controller
package clk_startup_pkg;
  // clock source select field codes (fuse bit 1 = unprogrammed)
  localparam logic [3:0] CSS_RC_OSC       = 4'h2;
  localparam logic [3:0] CSS_EXT_CLOCK    = 4'h0;
  localparam logic [1:0] SUT_SHIPPED      = 2'h2;
  localparam logic [3:0] CSS_SHIPPED      = 4'h2;
  localparam logic       DIV8_SHIPPED     = 1'b0;
  // start-up counts in selected-clock cycles
  localparam int unsigned CK_6            = 6;
  localparam int unsigned CK_14           = 14;
  localparam int unsigned CK_258          = 258;
  localparam int unsigned CK_1K           = 1024;
  localparam int unsigned CK_16K          = 16384;
  localparam int unsigned CK_32K          = 32768;
  // watchdog oscillator counts for the reset delay
  localparam int unsigned WDT_SHORT_CYC   = 4096;
  localparam int unsigned WDT_LONG_CYC    = 65536;
  // register byte offsets
  localparam logic [7:0] FUSE_OFF         = 8'h00;
  localparam logic [7:0] SLEEP_OFF        = 8'h04;
  localparam logic [7:0] STATUS_OFF       = 8'h08;
  localparam logic [7:0] GATE_OFF         = 8'h0C;
  // fuse register reset value: {div8, sut[1:0], css[3:0]}
  localparam logic [6:0] FUSE_RESET       = {DIV8_SHIPPED, SUT_SHIPPED, CSS_SHIPPED};
  localparam logic [1:0] AXI_OKAY         = 2'h0;
  localparam logic [1:0] AXI_SLVERR       = 2'h2;
  // sleep modes
  typedef enum logic [2:0] {
    SLP_IDLE, SLP_ADC_NR, SLP_PWR_DOWN, SLP_PWR_SAVE, SLP_STANDBY
  } sleep_mode_t;
  // clock source classes
  typedef enum logic [2:0] {
    SRC_XTAL, SRC_LF_XTAL, SRC_RC, SRC_EXT, SRC_BAD
  } source_t;
endpackage : clk_startup_pkg

// ===== design/startup_count_if.sv
// start/done handshake between the sequencer and a down counter
`timescale 1ns/100ps
`default_nettype none
interface startup_count_if;
  logic        start;
  logic [16:0] count;
  logic        tick;
  logic        done;
  modport ctrl (output start, output count, output tick, input done);
  modport cnt  (input start, input count, input tick, output done);
endinterface : startup_count_if
`default_nettype wire

// ===== design/startup_counter.sv
// enable-gated down counter that reports completion
`timescale 1ns/100ps
`default_nettype none
module startup_counter #(
  parameter int WIDTH = 17
) (
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // control
  startup_count_if.cnt   cif
);
  // refuse widths that cannot hold the longest count
  if (WIDTH < 17) begin : g_width_check
    $error("startup_counter width too small");
  end
  logic [WIDTH-1:0] left_r;
  logic             busy_r;
  // load on start, count on tick, signal done once at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_r <= '0;
      busy_r <= 1'b0;
    end else if (cif.start) begin
      left_r <= WIDTH'(cif.count);
      busy_r <= 1'b1;
    end else if (busy_r && cif.tick) begin
      if (left_r <= WIDTH'(1)) busy_r <= 1'b0;
      left_r <= (left_r == '0) ? '0 : left_r - WIDTH'(1);
    end
  end
  assign cif.done = !busy_r && !cif.start;
endmodule : startup_counter
`default_nettype wire

// ===== dv/css_sva.sv
// assertion checker for the clock start-up controller
`timescale 1ns/100ps
`default_nettype none
module css_sva (
  // clock, reset and inputs
  input wire logic       clk, rst_n, osc_running, serial_start_async,
  // clock domain enables
  input wire logic       core_clock_en, peripheral_clock_en, program_memory_clock_en,
  input wire logic       converter_clock_en, serial_start_wake, run_enable,
  // decoded configuration
  input wire logic [2:0] source_class, oscillator_band_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // gating relations between domains
  a_core_run: assert property (core_clock_en == run_enable)
    else $error("core gate differs from run state");
  a_flash_core: assert property (program_memory_clock_en == core_clock_en)
    else $error("program memory gate differs from core gate");
  a_periph_core: assert property (core_clock_en |-> peripheral_clock_en)
    else $error("peripheral gate off while core runs");
  a_conv_periph: assert property (peripheral_clock_en |-> converter_clock_en)
    else $error("converter gate off while peripheral runs");
  a_serial_wake: assert property (serial_start_wake |->
    serial_start_async && !peripheral_clock_en && !run_enable)
    else $error("serial wake without its cause");
  // decode relations and oscillator check at run start
  a_band_other: assert property (source_class != 3'h0 |-> oscillator_band_select == 3'h0)
    else $error("band set for non-crystal source");
  a_band_xtal: assert property (source_class == 3'h0 |-> oscillator_band_select[2])
    else $error("crystal band outside crystal codes");
  a_class_range: assert property (source_class <= 3'h4)
    else $error("source class out of range");
  a_run_osc: assert property ($rose(run_enable) |-> osc_running)
    else $error("run started without oscillator");
  // main scenarios
  c_run: cover property ($rose(run_enable));
  c_serial: cover property (serial_start_wake);
  c_idle: cover property (!run_enable && peripheral_clock_en);
endmodule : css_sva
bind clock_source_startup_control css_sva chk (.clk, .rst_n, .osc_running, .serial_start_async,
  .core_clock_en, .peripheral_clock_en, .program_memory_clock_en, .converter_clock_en,
  .serial_start_wake, .run_enable, .source_class, .oscillator_band_select);
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the clock start-up controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import clk_startup_pkg::*;
  logic clk, rst_n, wdt_tick, osc_running, sleep_req, wake_evt, serial_start_async, half;
  logic osc_tick = 1'h1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_b;
  logic core_clock_en, peripheral_clock_en, program_memory_clock_en, async_timer_clock_en;
  logic converter_clock_en, serial_start_wake, divide_by_eight_en, run_enable;
  logic [2:0] source_class, oscillator_band_select;
  int n_errors, checks;

  clock_source_startup_control uut (.clk, .rst_n, .osc_tick, .wdt_tick, .osc_running,
    .sleep_req, .wake_evt, .serial_start_async, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_clock_en,
    .peripheral_clock_en, .program_memory_clock_en, .async_timer_clock_en,
    .converter_clock_en, .serial_start_wake, .source_class, .oscillator_band_select,
    .divide_by_eight_en, .run_enable);

  // system clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // oscillator cycle enable, every other clock while half is set
  always @(posedge clk) osc_tick <= half ? !osc_tick : 1'h1;

  // verdict and end of run
  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rng(input int c, input int lo, input int hi);
    checks++;
    if (c < lo || c > hi) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, c, lo);
    end
  endtask : rng

  task automatic tmo;
    n_errors++;
    $display("[ERR] t=%0t wait expired", $time);
    final_report();
  endtask : tmo

  // axi4-lite write, items released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, pb, ta, tw, tb;
    pa = 1'h1;
    pw = 1'h1;
    pb = 1'h1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; pb; n++) begin
      @(negedge clk);
      if (n > 50) tmo();
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      tb = s_axi_bvalid;
      wr_b = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
      pa = pa && !ta;
      pw = pw && !tw;
      pb = !tb;
    end
  endtask : wr

  // axi4-lite read into rd_d and rd_r
  task automatic rd(input logic [7:0] a);
    logic pa, pr, ta, tr;
    pa = 1'h1;
    pr = 1'h1;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; pr; n++) begin
      @(negedge clk);
      if (n > 50) tmo();
      ta = pa && s_axi_arready;
      tr = s_axi_rvalid;
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
      pa = pa && !ta;
      pr = !tr;
    end
  endtask : rd

  // cycles until execution resumes
  task automatic wait_run(output int c);
    for (c = 0; c < 70000; c++) begin
      @(negedge clk);
      if (run_enable === 1'h1) return;
    end
    tmo();
  endtask : wait_run

  task automatic t_reset;
    int c;
    repeat (9) @(posedge clk);
    @(negedge clk);
    chk(run_enable, 1'h0);
    chk(core_clock_en, 1'h0);
    chk(async_timer_clock_en, 1'h1);
    chk(divide_by_eight_en, 1'h1);
    @(posedge clk);
    rst_n <= 1'h1;
    wait_run(c);
    rng(c, int'(WDT_LONG_CYC + CK_14), int'(WDT_LONG_CYC + CK_14) + 12);
    rd(FUSE_OFF);
    chk(rd_d, 32'(FUSE_RESET));
    chk(source_class, 3'h2);
    rd(STATUS_OFF);
    chk(rd_d & 32'h00000057, 32'h00000012);
    rd(GATE_OFF);
    chk(rd_d, 32'h0000001F);
    rd(8'h10);
    chk(rd_r, AXI_SLVERR);
    chk(rd_d, 32'h0);
    wr(8'h10, 32'h0);
    chk(wr_b, AXI_SLVERR);
    $display("reset test done");
  endtask : t_reset

  task automatic t_decode;
    logic [3:0] c;
    logic [2:0] ec;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      ec = c[3] ? 3'h0 : (c[3:1] == 3'h3) ? 3'h1 : (c == 4'h2) ? 3'h2 : (c == 4'h0) ? 3'h3 : 3'h4;
      wr(FUSE_OFF, {25'h0, 1'h1, 2'h1, c});
      chk(wr_b, AXI_OKAY);
      rd(STATUS_OFF);
      chk(rd_d[6], ec == 3'h4);
      rd(FUSE_OFF);
      chk(rd_d, {25'h0, 1'h1, 2'h1, c});
      chk(source_class, ec);
      chk(oscillator_band_select, c[3] ? c[3:1] : 3'h0);
      chk(divide_by_eight_en, 1'h0);
    end
    $display("decode test done");
  endtask : t_decode

  task automatic t_wake;
    int c;
    int md [7] = '{0, 1, 2, 3, 2, 2, 4};
    logic [3:0] cs [7] = '{4'h2, 4'h2, 4'h2, 4'h8, 4'h8, 4'h9, 4'h2};
    logic [1:0] su [7] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h2, 2'h1, 2'h2};
    int nn [7] = '{0, 0, 2 * CK_6, CK_258, CK_1K, CK_16K, 0};
    logic [1:0] gt [7] = '{2'h3, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    for (int i = 0; i < 7; i++) begin
      wr(FUSE_OFF, {25'h0, 1'h0, su[i], cs[i]});
      wr(SLEEP_OFF, 32'(md[i]));
      rd(SLEEP_OFF);
      chk(rd_d, 32'(md[i]));
      @(posedge clk);
      sleep_req <= 1'h1;
      @(posedge clk);
      sleep_req <= 1'h0;
      @(negedge clk);
      chk(program_memory_clock_en, 1'h0);
      chk({peripheral_clock_en, converter_clock_en}, gt[i]);
      if (cs[i] == 4'h2) chk(async_timer_clock_en, 1'h1);
      @(posedge clk);
      if (i == 2) serial_start_async <= 1'h1;
      else wake_evt <= 1'h1;
      osc_running <= (i != 3);
      half <= (i == 2);
      @(negedge clk);
      chk(serial_start_wake, i == 2);
      if (i == 3) begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(run_enable, 1'h0);
        @(posedge clk);
        osc_running <= 1'h1;
      end
      wait_run(c);
      rng(c, nn[i] - 1, nn[i] + 10);
      @(posedge clk);
      wake_evt <= 1'h0;
      serial_start_async <= 1'h0;
      half <= 1'h0;
    end
    wr(SLEEP_OFF, 32'h7);
    rd(SLEEP_OFF);
    chk(rd_d, 32'h4);
    $display("wake test done");
  endtask : t_wake

  // main sequence
  initial begin
    {sleep_req, wake_evt, serial_start_async, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, rst_n} = '0;
    {wdt_tick, osc_running} = 2'h3;
    half = 1'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    n_errors = 0;
    checks = 0;
    t_reset();
    t_decode();
    t_wake();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
